// ==== logic/twe_pkg.sv ====
// shared constants and types of the two-wire serial eeprom port
`default_nettype none

package twe_pkg;

  // clock and programming time
  localparam int CLK_PERIOD_NS     = 5;
  localparam int PROG_TIME_NS      = 5_000_000;
  // longest time: integer division rounds down
  localparam int PROG_CYCLES       = PROG_TIME_NS / CLK_PERIOD_NS;

  // array geometry and write fifo depth
  localparam int ADDR_W            = 14;
  localparam int PAGE_W            = 8;
  localparam int OFF_W             = 6;
  localparam int PAGE_BYTES        = 64;
  localparam int MEM_BYTES         = 16384;
  localparam int FIFO_DEPTH        = 8;

  // device address type code, last bit of a byte, last offset in a page
  localparam logic [3:0] DEV_TYPE  = 4'hA;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [5:0] LAST_OFF  = 6'h3F;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_RECV = 3'h1,
    PH_ACK  = 3'h2,
    PH_SEND = 3'h3,
    PH_MACK = 3'h4
  } twe_phase_t;

  typedef enum logic [1:0] {
    BY_DEV  = 2'h0,
    BY_AHI  = 2'h1,
    BY_ALO  = 2'h2,
    BY_DATA = 2'h3
  } twe_byte_t;

  typedef enum logic [1:0] {
    PR_NONE  = 2'h0,
    PR_DRAIN = 2'h1,
    PR_COPY  = 2'h2,
    PR_WAIT  = 2'h3
  } twe_prog_t;

  // one received data byte and its place in the page
  typedef struct packed {
    logic [OFF_W-1:0] off;
    logic [7:0]       data;
  } twe_wbyte_t;

  // pin sample as it moves through the synchroniser
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] cs;
  } twe_pins_t;

  typedef struct packed {
    twe_pins_t         p1;
    twe_pins_t         p2;
    logic              scl_d;
    logic              sda_d;
    twe_phase_t        phase;
    twe_byte_t         kind;
    logic [2:0]        bitc;
    logic              done;
    logic              ack_ok;
    logic              rd;
    logic [7:0]        shreg;
    logic [OFF_W-1:0]  hi;
    logic [ADDR_W-1:0] addr;
    logic              pend;
    logic [63:0]       mask;
    twe_prog_t         prog;
    logic [OFF_W-1:0]  copy;
    logic [31:0]       timer;
    logic              sda_o;
    logic              oe_n;
    logic              standby;
    logic              busy;
  } twe_state_t;

endpackage : twe_pkg

`default_nettype wire

// ==== logic/twe_eeprom.sv ====
// two-wire serial eeprom target: write fifo and protocol engine
// Operation
// (R1) serial data is only pulled low or released, never driven high
// (R2) sample data on clock rise, change outgoing data after clock fall
// (R3) data change while clock high is a start or stop
// (R4) falling data with clock high is start; traffic without start ignored
// (R5) stop, once internal work ends, puts device into standby
// (R6) 8-bit words, each received word acknowledged low on ninth clock
// (R7) controller recovers bus with up to 9 clocks then a start
// (R8) three chip-select bits compared against the three strap pins
// (R9) unconnected strap pins read as logic low
// (R10) last address bit high means read, low means write
// (R11) address match acknowledged; mismatch unacknowledged, back to standby
// (R12) write protect high refuses programming of the whole array
// (R13) 256 pages of 64 bytes, 14-bit word address
// (R14) byte write: device address, word address, data, then stop
// (R15) stop after write starts self-timed cycle up to 5 ms, inputs ignored
// (R16) page write takes up to 63 more bytes, each acknowledged
// (R17) only low six address bits increment on writes, wrapping in page
// (R18) while programming the device address is not acknowledged
// (R19) address counter holds last address plus one, reads wrap memory end
// (R20) current read sends byte at counter; controller withholds ack, stops
// (R21) random read: dummy write of address, repeated start, current read
// (R22) controller ack makes device advance and send next byte
// (R23) device word is 1010, three select bits, direction bit
// (R24) controller ends sequential read by no ack and stop
// (R25) word address sent high byte first, top two bits ignored
`timescale 1ns/100ps
`default_nettype none

module twe_fifo
  import twe_pkg::*;
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // depth must be a power of two
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } twe_fifo_st_t;

  twe_fifo_st_t     st;
  twe_fifo_st_t     next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = st.cnt != (AW+1)'(DEPTH);
  assign out_valid = st.cnt != '0;
  assign out_data  = mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    unique case ({push, pop})
      2'b10:   next_st.cnt = st.cnt + 1'b1;
      2'b01:   next_st.cnt = st.cnt - 1'b1;
      default: next_st.cnt = st.cnt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wp] <= in_data;
    end
  end
endmodule // twe_fifo

module twe_eeprom
  import twe_pkg::*;
#(
  parameter int unsigned PROG_LEN = PROG_CYCLES
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // serial bus
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  // straps and protection
  input  wire logic [2:0] CHIP_SELECT_STRAPS,
  input  wire logic       WP,
  // status
  output logic            STANDBY,
  output logic            BUSY
);
  twe_state_t  st;
  twe_state_t  next_st;
  logic [7:0]  mem  [MEM_BYTES];
  logic [7:0]  pbuf [PAGE_BYTES];
  logic [7:0]  rd_q;
  logic [7:0]  rx;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        ok;
  logic        mem_we;
  logic        f_push;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_ready;
  twe_wbyte_t  f_in;
  twe_wbyte_t  f_out;

  // edges seen on the second synchroniser stage only
  assign scl_rise    = st.p2.scl && !st.scl_d;
  assign scl_fall    = !st.p2.scl && st.scl_d;
  assign start_c     = st.p2.scl && st.scl_d && st.sda_d && !st.p2.sda; // (R3)
  assign stop_c      = st.p2.scl && st.scl_d && !st.sda_d && st.p2.sda; // (R3)
  assign rx          = {st.shreg[6:0], st.p2.sda}; // (R2)
  assign f_out_ready = st.prog != PR_COPY;

  assign SDA_OUT  = st.sda_o;
  assign SDA_OE_N = st.oe_n;
  assign STANDBY  = st.standby;
  assign BUSY     = st.busy;

  twe_fifo #(
    .WIDTH ($bits(twe_wbyte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rstn      (RSTN),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (f_in),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out)
  );

  always_comb begin
    next_st       = st;
    ok            = 1'b0;
    f_push        = 1'b0;
    f_in.off      = st.addr[OFF_W-1:0];
    f_in.data     = rx;
    mem_we        = 1'b0;
    next_st.p1    = '{SCL, SDA_IN, WP, CHIP_SELECT_STRAPS};
    next_st.p2    = st.p1;
    next_st.scl_d = st.p2.scl;
    next_st.sda_d = st.p2.sda;

    unique case (st.phase)
      PH_RECV: begin
        if (scl_rise) begin
          next_st.shreg = rx;
          next_st.bitc  = st.bitc + 1'b1;
          if (st.bitc == LAST_BIT) begin
            next_st.done = 1'b1;
            unique case (st.kind)
              BY_DEV: begin
                // floating straps are biased low at the pad (R9)
                ok         = rx[7:4] == DEV_TYPE && rx[3:1] == st.p2.cs; // (R8) (R23)
                next_st.rd = rx[0]; // (R10)
              end
              BY_AHI: begin
                ok         = 1'b1;
                next_st.hi = rx[OFF_W-1:0]; // (R25)
              end
              BY_ALO: begin
                ok           = 1'b1;
                next_st.addr = {st.hi, rx}; // (R13)
              end
              BY_DATA: begin
                // a full fifo withholds the acknowledge instead of losing data
                ok     = f_in_ready; // (R16)
                f_push = ok;
                if (ok) begin
                  next_st.addr[OFF_W-1:0] = st.addr[OFF_W-1:0] + 1'b1; // (R17)
                  next_st.pend            = 1'b1;
                end
              end
            endcase
            next_st.ack_ok = ok;
          end
        end else if (scl_fall && st.done) begin
          next_st.done = 1'b0;
          if (st.ack_ok) begin
            next_st.phase = PH_ACK;
            next_st.oe_n  = 1'b0; // (R6) (R11)
          end else begin
            next_st.phase = PH_IDLE; // (R11)
          end
        end
      end
      PH_ACK: begin
        if (scl_fall) begin
          next_st.bitc = '0;
          if (st.rd) begin
            next_st.phase = PH_SEND;
            next_st.shreg = rd_q; // (R20)
            next_st.oe_n  = rd_q[7]; // (R1)
            next_st.addr  = st.addr + 1'b1; // (R19)
          end else begin
            next_st.phase = PH_RECV;
            next_st.oe_n  = 1'b1;
            unique case (st.kind) // (R14)
              BY_DEV:  next_st.kind = BY_AHI;
              BY_AHI:  next_st.kind = BY_ALO;
              default: next_st.kind = BY_DATA;
            endcase
          end
        end
      end
      PH_SEND: begin
        if (scl_rise) begin
          next_st.bitc = st.bitc + 1'b1;
          next_st.done = st.bitc == LAST_BIT;
        end else if (scl_fall) begin
          if (st.done) begin
            next_st.done  = 1'b0;
            next_st.phase = PH_MACK;
            next_st.oe_n  = 1'b1;
          end else begin
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.oe_n  = st.shreg[6]; // (R1) (R2)
          end
        end
      end
      PH_MACK: begin
        if (scl_rise) begin
          next_st.ack_ok = !st.p2.sda;
        end else if (scl_fall) begin
          next_st.bitc = '0;
          if (st.ack_ok) begin
            next_st.phase = PH_SEND; // (R22)
            next_st.shreg = rd_q;
            next_st.oe_n  = rd_q[7];
            next_st.addr  = st.addr + 1'b1; // (R19)
          end else begin
            next_st.phase = PH_IDLE; // (R20)
          end
        end
      end
      PH_IDLE: begin
        next_st.oe_n = 1'b1;
      end
      default: begin
        next_st.phase = PH_IDLE;
        next_st.oe_n  = 1'b1;
      end
    endcase

    // programming keeps the engine deaf, so polls go unanswered
    if (start_c && st.prog == PR_NONE) begin // (R4) (R18)
      next_st.phase = PH_RECV;
      next_st.kind  = BY_DEV;
      next_st.bitc  = '0;
      next_st.done  = 1'b0;
      next_st.rd    = 1'b0;
      next_st.oe_n  = 1'b1;
    end else if (stop_c) begin
      next_st.phase = PH_IDLE; // (R5)
      next_st.done  = 1'b0;
      next_st.oe_n  = 1'b1;
      if (st.pend) begin
        next_st.pend = 1'b0;
        next_st.prog = PR_DRAIN; // (R15)
      end
    end

    // page latch filled from the fifo
    if (f_out_valid && f_out_ready) begin
      next_st.mask[f_out.off] = 1'b1;
    end

    unique case (st.prog)
      PR_DRAIN: begin
        if (!f_out_valid) begin
          next_st.copy = '0;
          if (st.p2.wp) begin
            next_st.prog = PR_NONE; // (R12)
            next_st.mask = '0;
          end else begin
            next_st.prog = PR_COPY;
          end
        end
      end
      PR_COPY: begin
        mem_we       = st.mask[st.copy] && !st.p2.wp; // (R12)
        next_st.copy = st.copy + 1'b1;
        if (st.copy == LAST_OFF) begin
          next_st.mask  = '0;
          next_st.timer = '0;
          next_st.prog  = PR_WAIT;
        end
      end
      PR_WAIT: begin
        next_st.timer = st.timer + 1'b1;
        if (st.timer >= PROG_LEN - 1) begin
          next_st.prog = PR_NONE; // (R15)
        end
      end
      PR_NONE: begin
      end
    endcase

    next_st.busy    = next_st.prog != PR_NONE;
    next_st.standby = next_st.phase == PH_IDLE && next_st.prog == PR_NONE; // (R5)
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st         <= '0;
      st.p1      <= '{1'b1, 1'b1, 1'b0, 3'h0};
      st.p2      <= '{1'b1, 1'b1, 1'b0, 3'h0};
      st.scl_d   <= 1'b1;
      st.sda_d   <= 1'b1;
      st.oe_n    <= 1'b1;
      st.standby <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // array and page latch; registered read follows the counter
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[{st.addr[ADDR_W-1:OFF_W], st.copy}] <= pbuf[st.copy]; // (R13) (R17)
    end
    if (f_out_valid && f_out_ready) begin
      pbuf[f_out.off] <= f_out.data;
    end
    rd_q <= mem[st.addr];
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  only_pull_low_a: assert property ( // (R1)
    SDA_OUT == 1'b0
  ) else $error("serial data driven high");

  drive_after_fall_a: assert property ( // (R2)
    $fell(SDA_OE_N) |-> $past(scl_fall)
  ) else $error("data line pulled low outside clock low");

  start_needed_a: assert property ( // (R4)
    (st.phase == PH_RECV && $past(st.phase) == PH_IDLE) |-> $past(start_c)
  ) else $error("reception began without start");

  stop_to_idle_a: assert property ( // (R5)
    stop_c |=> st.phase == PH_IDLE && SDA_OE_N
  ) else $error("stop did not release the bus");

  ack_low_a: assert property ( // (R6)
    st.phase == PH_ACK |-> !SDA_OE_N
  ) else $error("acknowledge not held low");

  match_only_a: assert property ( // (R11)
    (st.phase == PH_ACK && st.kind == BY_DEV) |->
      st.shreg[7:1] == {DEV_TYPE, st.p2.cs}
  ) else $error("acknowledged a foreign device address");

  protect_array_a: assert property ( // (R12)
    mem_we |-> !st.p2.wp
  ) else $error("array programmed under write protect");

  busy_deaf_a: assert property ( // (R18)
    st.busy |-> st.phase == PH_IDLE && SDA_OE_N
  ) else $error("device answered while programming");

  page_fixed_a: assert property ( // (R17)
    f_push |=> st.addr[ADDR_W-1:OFF_W] == $past(st.addr[ADDR_W-1:OFF_W])
  ) else $error("page bits moved during write");

  prog_bound_a: assert property ( // (R15)
    st.prog == PR_WAIT |-> st.timer < PROG_LEN
  ) else $error("programming cycle overran");

  read_advance_a: assert property ( // (R19)
    (st.phase == PH_SEND && $past(st.phase) != PH_SEND) |->
      st.addr == $past(st.addr) + 1'b1
  ) else $error("read did not advance the counter");

endmodule // twe_eeprom

`default_nettype wire

// ==== test/twe_ctl_model.sv ====
// two-wire bus controller model that drives the serial clock
`timescale 1ns/100ps
`default_nettype none

module twe_ctl_model
  import twe_pkg::*;
(
  // clock
  input  wire logic clk,
  // serial bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // short pause after the fall so no data edge meets a clock edge
  task automatic bitx(input logic b, output logic r);
    hc(2);
    sda_rel = b;
    hc(8);
    scl = 1'b1;
    hc(5);
    r = sda;
    hc(5);
    scl = 1'b0;
  endtask

  task automatic start();
    hc(2);
    sda_rel = 1'b1;
    hc(6);
    scl = 1'b1;
    hc(10);
    sda_rel = 1'b0;
    hc(10);
    scl = 1'b0;
  endtask

  task automatic stop();
    hc(2);
    sda_rel = 1'b0;
    hc(8);
    scl = 1'b1;
    hc(10);
    sda_rel = 1'b1;
    hc(10);
  endtask

  // clock a stuck target until data reads high, then start at once;
  // starting while the clock is still high avoids a target that drives again
  task automatic recover(output logic found);
    found = 1'b0;
    for (int i = 0; i < 9 && !found; i++) begin
      hc(2);
      sda_rel = 1'b1;
      hc(8);
      scl = 1'b1;
      hc(5);
      found = sda;
      if (!found) begin
        hc(5);
        scl = 1'b0;
      end
    end
    if (found) begin
      hc(5);
      sda_rel = 1'b0;
      hc(10);
      scl = 1'b0;
    end
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // twe_ctl_model

`default_nettype wire

// ==== test/twe_eeprom_test.sv ====
// self-checking testbench of the serial eeprom port
`timescale 1ns/100ps
`default_nettype none

module twe_eeprom_test
  import twe_pkg::*;
;
  localparam logic [2:0] STRAP = 3'h5;

  logic       clk;
  logic       rstn;
  logic       wp;
  logic       sda_out;
  logic       sda_oe_n;
  logic       standby;
  logic       busy;
  logic       scl;
  logic       sda_rel;
  logic       sda;
  logic       ack;
  logic [7:0] rd;
  int         miscompares;
  int         samples_checked;

  // pull-up wire shared by both open-drain parties
  assign sda = sda_oe_n ? sda_rel : (sda_out & sda_rel);

  twe_eeprom #(.PROG_LEN(400)) dut_u (
    .CLK(clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .CHIP_SELECT_STRAPS(STRAP), .WP(wp),
    .STANDBY(standby), .BUSY(busy));

  twe_ctl_model ctl_u (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic seta(input logic [13:0] a);
    ctl_u.start();
    ctl_u.wbyte({DEV_TYPE, STRAP, 1'b0}, ack);
    chk(ack, 1'b1);
    ctl_u.wbyte({2'b11, a[13:8]}, ack);
    chk(ack, 1'b1);
    ctl_u.wbyte(a[7:0], ack);
    chk(ack, 1'b1);
  endtask

  task automatic put(input logic [13:0] a, input int n, input logic [7:0] base);
    seta(a);
    for (int i = 0; i < n; i++) begin
      ctl_u.wbyte(base + 8'(i), ack);
      chk(ack, 1'b1);
    end
    ctl_u.stop();
  endtask

  task automatic idle_wait();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(negedge clk);
      k++;
    end
  endtask

  // poll during the cycle, then poll again once it is over
  task automatic prog_wait();
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk(busy, 1'b1);
    chk(standby, 1'b0);
    ctl_u.start();
    ctl_u.wbyte({DEV_TYPE, STRAP, 1'b0}, ack);
    chk(ack, 1'b0);
    idle_wait();
    chk(busy, 1'b0);
    ctl_u.start();
    ctl_u.wbyte({DEV_TYPE, STRAP, 1'b0}, ack);
    chk(ack, 1'b1);
    ctl_u.stop();
    chk(standby, 1'b1);
  endtask

  task automatic rd_at(input logic [13:0] a, input logic [7:0] e0, input logic [7:0] e1);
    seta(a);
    ctl_u.start();
    ctl_u.wbyte({DEV_TYPE, STRAP, 1'b1}, ack);
    chk(ack, 1'b1);
    ctl_u.rbyte(1'b0, rd);
    chk(rd, e0);
    ctl_u.rbyte(1'b1, rd);
    chk(rd, e1);
    ctl_u.stop();
  endtask

  // every wrong strap code, plus a wrong type code with the right straps
  task automatic t_miss();
    for (int s = 0; s < 8; s++) begin
      ctl_u.start();
      ctl_u.wbyte({(3'(s) == STRAP) ? 4'hB : DEV_TYPE, 3'(s), 1'b0}, ack);
      chk(ack, 1'b0);
    end
    ctl_u.stop();
    chk(standby, 1'b1);
    $display("test address mismatch done");
  endtask

  task automatic t_page();
    put(14'h053E, 4, 8'h10);
    prog_wait();
    rd_at(14'h0500, 8'h12, 8'h13);
    rd_at(14'h053E, 8'h10, 8'h11);
    $display("test page write done");
  endtask

  // read cut short while data is low, bus cleared by clocking, then a current read
  task automatic t_recov();
    logic found;
    seta(14'h0500);
    ctl_u.start();
    ctl_u.wbyte({DEV_TYPE, STRAP, 1'b1}, ack);
    chk(ack, 1'b1);
    ctl_u.recover(found);
    chk(found, 1'b1);
    ctl_u.wbyte({DEV_TYPE, STRAP, 1'b1}, ack);
    chk(ack, 1'b1);
    ctl_u.rbyte(1'b1, rd);
    chk(rd, 8'h13);
    ctl_u.stop();
    $display("test bus recovery done");
  endtask

  task automatic t_prot();
    wp = 1'b1;
    put(14'h053E, 1, 8'hEE);
    chk(busy, 1'b0);
    idle_wait();
    wp = 1'b0;
    rd_at(14'h053E, 8'h10, 8'h11);
    $display("test write protect done");
  endtask

  task automatic t_wrap();
    put(14'h3FFF, 1, 8'h55);
    prog_wait();
    put(14'h0000, 1, 8'h66);
    prog_wait();
    rd_at(14'h3FFF, 8'h55, 8'h66);
    $display("test memory wrap done");
  endtask

  initial begin
    miscompares = 0;
    samples_checked = 0;
    rstn = 1'b0;
    wp = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    chk(sda_oe_n, 1'b1);
    t_miss();
    t_page();
    t_recov();
    t_prot();
    t_wrap();
    chk(sda_out, 1'b0);
    complete_run();
  end

  // whole run needs about 13400 cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule // twe_eeprom_test

`default_nettype wire
